// file: aid_host_model.sv
`default_nettype none
module aid_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Upstream request and grant
  input wire logic upReq,
  input wire logic [1:0] grantDelay,
  output logic upGrant
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waitReg;

  always_ff @(posedge clk_sys) begin
    if (rst || !upReq) begin
      waitReg <= 2'h0;
      upGrant <= 1'b0;
    end else if (waitReg == grantDelay) begin
      upGrant <= 1'b1;
    end else begin
      waitReg <= waitReg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: aid_msg_irq_ctrl.sv
// Function
// - Remote read reply ends with data checksum in cycle 38, idle ones in 39.
// - Remote read is never retried, whatever its data status.
// - Write-based PCI messages accepted only while the interrupt unit is enabled.
// - Pin assertion register decoded as memory target at fixed APIC window address.
// - Claim pin assertion writes with medium decode, only when capability flag set.
// - Numbers 1 to 23 other than 2, 8 and 13 set the request bit of an edge-triggered entry; level-triggered entries and others do nothing.
// - Messages naming interrupt 0, 2, 8 or 13 are ignored.
// - Pending request forwarded as a message, then cleared by hardware.
// - Capability flag reads zero while extended mode enable is clear.
// - Parallel delivery only when unit enable and delivery select both set.
// - Edge or level change events set or clear the request bit.
// - Request the upstream path, flushing posted buffers, before the write.
// - Edge inputs send assert on each rising edge, never deassert.
// - Level inputs assert on rising edge and again if active after EOI.
// - Each message is a single 32-bit memory write upstream.
// - Address bits 31:20 are FEEh, bits 11:4 and 1:0 zero.
// - Address bits 19:12 carry the entry's destination ID.
// - Address bit 3 set only for lowest priority; bit 2 destination mode.
// - Data 31:16, 13:12 zero; 15 trigger, 11 dest mode, 7:0 vector.
// - Data bit 14 is one for edge, input state for level.
// - Data 10:8 carry delivery mode; SMI, NMI, INIT never generated.
`default_nettype none
module aid_msg_irq_ctrl #(
  parameter int NUM_IRQ = aid_pkg::IRQ_COUNT,
  parameter bit PIN_ASSERT_SUPPORT = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic interruptUnitEnable,
  input wire logic extendedModeEnable,
  input wire logic parallelDeliverySelect,
  output logic pinAssertCapableFlag,
  // Interrupt pins
  input wire logic [NUM_IRQ-1:0] irqPin,
  // Redirection entries
  input wire logic [NUM_IRQ*8-1:0] rteDestId,
  input wire logic [NUM_IRQ*8-1:0] rteVector,
  input wire logic [NUM_IRQ*3-1:0] rteDelivMode,
  input wire logic [NUM_IRQ-1:0] rteDestLogical,
  input wire logic [NUM_IRQ-1:0] rteLevelTrig,
  // End of interrupt
  input wire logic eoiValid,
  input wire logic [7:0] eoiVector,
  // PCI memory write target
  input wire logic tgtWrite,
  input wire logic [31:0] tgtAddr,
  input wire logic [31:0] tgtData,
  output logic tgtClaim,
  // Upstream message write
  output logic upReq,
  input wire logic upGrant,
  output logic msgWrite,
  output logic [31:0] msgAddr,
  output logic [31:0] msgData,
  // Pending view
  output logic [NUM_IRQ-1:0] requestPendingBit,
  // Remote read responder
  input wire logic rrStart,
  input wire logic [31:0] rrData,
  input wire logic rrDataValid,
  output logic rrDrive,
  output logic [1:0] rrBits
);
  import aid_pkg::*;

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 32) $error("aid_msg_irq_ctrl: NUM_IRQ must be 1..32");
  end

  logic [NUM_IRQ-1:0] lvl, prev_reg, rise, fall;
  logic [NUM_IRQ-1:0] irr_reg, irr_next, remote_reg, remote_next, pciSet, eoiHit, eligible;
  logic parallelMode, pciHit, claim_next, cap_next;
  logic [IRQ_NUM_W-1:0] pciNum;
  aid_state_t state_reg, state_next;
  logic [4:0] sel_reg, sel_next, pick;
  logic upReq_next, msgWrite_next, doneDeliver;
  logic [31:0] msgAddr_next, msgData_next;
  logic [2:0] selMode;
  logic selBlocked;

  aid_pin_sync #(.WIDTH(NUM_IRQ)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(irqPin),
    .level(lvl)
  );

  assign rise = lvl & ~prev_reg;
  assign fall = ~lvl & prev_reg;
  assign parallelMode = interruptUnitEnable & parallelDeliverySelect;

  // only the low bits of the payload
  assign pciNum = tgtData[IRQ_NUM_W-1:0];
  // decode of the pin assertion location
  assign pciHit = tgtWrite && tgtAddr == PIN_ASSERT_ADDR && pinAssertCapableFlag && interruptUnitEnable;

  always_comb begin
    pciSet = '0;
    if (pciHit && 32'(pciNum) < NUM_IRQ && pciNum != IRQ_IGN_A && pciNum != IRQ_IGN_B &&
        pciNum != IRQ_IGN_C && pciNum != IRQ_IGN_D) begin
      pciSet[pciNum] = 1'b1;
    end
  end

  always_comb begin
    claim_next = pciHit;
    cap_next = PIN_ASSERT_SUPPORT & extendedModeEnable;
  end

  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      eoiHit[i] = eoiValid && rteLevelTrig[i] && remote_reg[i] && rteVector[i*8 +: 8] == eoiVector;
    end
  end

  assign doneDeliver = (state_reg == ST_WRITE) || (state_reg == ST_REQ && selBlocked);

  always_comb begin
    irr_next = irr_reg;
    remote_next = remote_reg;
    for (int i = 0; i < NUM_IRQ; i++) begin
      // hardware clear after delivery, new events win
      if (doneDeliver && 32'(sel_reg) == i) begin
        irr_next[i] = 1'b0;
        remote_next[i] = rteLevelTrig[i] && !selBlocked;
      end
      if (eoiHit[i]) begin
        remote_next[i] = 1'b0;
      end
      if (rteLevelTrig[i]) begin
        if (fall[i]) begin
          irr_next[i] = 1'b0;
        end
        // rising edge, or still active after EOI
        if (rise[i] || (eoiHit[i] && lvl[i])) begin
          irr_next[i] = 1'b1;
        end
      end else begin
        if (rise[i] || pciSet[i]) begin
          irr_next[i] = 1'b1;
        end
      end
    end
  end

  assign eligible = irr_reg & ~remote_reg;

  always_comb begin
    pick = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        pick = 5'(i);
      end
    end
  end

  assign selMode = rteDelivMode[sel_reg*3 +: 3];
  // unsupported and reserved modes are dropped
  assign selBlocked = selMode == DM_SMI || selMode == DM_NMI || selMode == DM_INIT ||
                      selMode == DM_RSVD_A || selMode == DM_RSVD_B;

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    upReq_next = 1'b0;
    msgWrite_next = 1'b0;
    msgAddr_next = msgAddr;
    msgData_next = msgData;
    unique case (state_reg)
      ST_IDLE: begin
        if (parallelMode && |eligible) begin
          sel_next = pick;
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (selBlocked) begin
          state_next = ST_IDLE;
        end else if (upGrant && upReq) begin
          msgWrite_next = 1'b1;
          msgAddr_next = {MSG_ADDR_TOP, rteDestId[sel_reg*8 +: 8], MSG_ADDR_RSVD,
                          selMode == DM_LOWEST, rteDestLogical[sel_reg], MSG_ADDR_LOW};
          msgData_next = {MSG_DATA_TOP, rteLevelTrig[sel_reg], !rteLevelTrig[sel_reg] || lvl[sel_reg],
                          MSG_DATA_RSVD, rteDestLogical[sel_reg], selMode, rteVector[sel_reg*8 +: 8]};
          state_next = ST_WRITE;
        end else begin
          upReq_next = 1'b1;
        end
      end
      ST_WRITE: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_reg <= '0;
      irr_reg <= '0;
      remote_reg <= '0;
      tgtClaim <= 1'b0;
      pinAssertCapableFlag <= 1'b0;
      state_reg <= ST_IDLE;
      sel_reg <= '0;
      upReq <= 1'b0;
      msgWrite <= 1'b0;
      msgAddr <= '0;
      msgData <= '0;
    end else begin
      prev_reg <= lvl;
      irr_reg <= irr_next;
      remote_reg <= remote_next;
      tgtClaim <= claim_next;
      pinAssertCapableFlag <= cap_next;
      state_reg <= state_next;
      sel_reg <= sel_next;
      upReq <= upReq_next;
      msgWrite <= msgWrite_next;
      msgAddr <= msgAddr_next;
      msgData <= msgData_next;
    end
  end

  assign requestPendingBit = irr_reg;

  // Remote read reply, cycles 21 to 39
  logic [4:0] rrCnt_reg, rrCnt_next;
  logic [31:0] rrSh_reg, rrSh_next;
  logic [1:0] rrStat_reg, rrStat_next, rrSum_reg, rrSum_next, rrBits_next;
  logic rrDrive_next;

  function automatic logic [1:0] pair_sum(input logic [31:0] d);
    logic [1:0] s;
    s = '0;
    for (int k = 0; k < 16; k++) begin
      s = s + d[2*k +: 2];
    end
    return s;
  endfunction

  always_comb begin
    rrCnt_next = rrCnt_reg;
    rrSh_next = rrSh_reg;
    rrStat_next = rrStat_reg;
    rrSum_next = rrSum_reg;
    rrDrive_next = rrDrive;
    rrBits_next = BUS_IDLE;
    if (!rrDrive) begin
      if (rrStart) begin
        rrDrive_next = 1'b1;
        rrCnt_next = '0;
        rrBits_next = rrData[31:30];
        rrSh_next = {rrData[29:0], 2'h0};
        rrStat_next = rrDataValid ? RR_STAT_VALID : RR_STAT_INVALID;
        rrSum_next = pair_sum(rrData);
      end
    end else begin
      rrCnt_next = rrCnt_reg + 5'd1;
      if (rrCnt_reg < RR_DATA_LAST) begin
        rrBits_next = rrSh_reg[31:30];
        rrSh_next = {rrSh_reg[29:0], 2'h0};
      end else if (rrCnt_next == RR_STATUS_CYC) begin
        rrBits_next = rrStat_reg;
      end else if (rrCnt_next == RR_SUM_CYC) begin
        rrBits_next = rrSum_reg;
      end else if (rrCnt_next == RR_IDLE_CYC) begin
        rrBits_next = BUS_IDLE;
      end else begin
        rrDrive_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rrCnt_reg <= '0;
      rrSh_reg <= '0;
      rrStat_reg <= '0;
      rrSum_reg <= '0;
      rrDrive <= 1'b0;
      rrBits <= BUS_IDLE;
    end else begin
      rrCnt_reg <= rrCnt_next;
      rrSh_reg <= rrSh_next;
      rrStat_reg <= rrStat_next;
      rrSum_reg <= rrSum_next;
      rrDrive <= rrDrive_next;
      rrBits <= rrBits_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rr_begin;
    rrStart && !rrDrive;
  endsequence
  sequence s_granted;
    upReq && upGrant;
  endsequence

  a_claim_medium: assert property (tgtWrite && tgtAddr == PIN_ASSERT_ADDR && pinAssertCapableFlag &&
    interruptUnitEnable |=> tgtClaim) else $error("pin assertion write not claimed");
  a_claim_enable: assert property (tgtClaim |-> $past(interruptUnitEnable))
    else $error("claim while unit disabled");
  a_flag_gated: assert property (!extendedModeEnable |=> !pinAssertCapableFlag)
    else $error("capability flag set without extended mode");
  a_write_after_req: assert property (msgWrite |-> $past(upReq) && $past(upGrant))
    else $error("message write without upstream grant");
  a_single_write: assert property (s_granted |=> msgWrite ##1 !msgWrite)
    else $error("message write not single");
  a_addr_layout: assert property (msgWrite |-> msgAddr[31:20] == MSG_ADDR_TOP &&
    msgAddr[11:4] == MSG_ADDR_RSVD && msgAddr[1:0] == MSG_ADDR_LOW) else $error("bad message address");
  a_hint_mode: assert property (msgWrite |-> msgAddr[3] == (msgData[10:8] == DM_LOWEST) &&
    msgAddr[2] == msgData[11]) else $error("bad redirection hint");
  a_data_layout: assert property (msgWrite |-> msgData[31:16] == MSG_DATA_TOP &&
    msgData[13:12] == MSG_DATA_RSVD && (msgData[15] || msgData[14])) else $error("bad message data");
  a_no_smi: assert property (msgWrite |-> msgData[10:8] != DM_SMI && msgData[10:8] != DM_NMI &&
    msgData[10:8] != DM_INIT) else $error("unsupported delivery mode sent");
  a_mode_gate: assert property (state_reg == ST_IDLE && state_next == ST_REQ |-> parallelMode)
    else $error("delivery started outside parallel mode");
  a_rr_tail: assert property (s_rr_begin |-> ##18 (rrBits == $past(rrSum_reg)) ##1
    (rrDrive && rrBits == BUS_IDLE) ##1 !rrDrive) else $error("remote read tail wrong");
endmodule
`default_nettype wire

// file: aid_pin_sync.sv
`default_nettype none
module aid_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;

  initial begin
    if (WIDTH < 1) $error("aid_pin_sync: WIDTH must be positive");
  end

  // Level moves only when the second and third stages agree
  always_comb begin
    lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;
endmodule
`default_nettype wire

// file: aid_pkg.sv
`default_nettype none
package aid_pkg;
  // Memory target of the pin assertion register
  localparam logic [31:0] APIC_WINDOW_BASE = 32'hfec0_0000;
  localparam logic [31:0] PIN_ASSERT_OFS = 32'h0000_0020;
  localparam logic [31:0] PIN_ASSERT_ADDR = APIC_WINDOW_BASE + PIN_ASSERT_OFS;
  // Interrupt number field of the written payload
  localparam int IRQ_NUM_W = 5;
  localparam int IRQ_COUNT = 24;
  localparam logic [IRQ_NUM_W-1:0] IRQ_IGN_A = 5'h00;
  localparam logic [IRQ_NUM_W-1:0] IRQ_IGN_B = 5'h02;
  localparam logic [IRQ_NUM_W-1:0] IRQ_IGN_C = 5'h08;
  localparam logic [IRQ_NUM_W-1:0] IRQ_IGN_D = 5'h0d;
  // Outbound message address layout
  localparam logic [11:0] MSG_ADDR_TOP = 12'hfee;
  localparam logic [7:0] MSG_ADDR_RSVD = 8'h00;
  localparam logic [1:0] MSG_ADDR_LOW = 2'h0;
  // Outbound message data layout
  localparam logic [15:0] MSG_DATA_TOP = 16'h0000;
  localparam logic [1:0] MSG_DATA_RSVD = 2'h0;
  // Delivery modes
  localparam logic [2:0] DM_FIXED = 3'h0;
  localparam logic [2:0] DM_LOWEST = 3'h1;
  localparam logic [2:0] DM_SMI = 3'h2;
  localparam logic [2:0] DM_RSVD_A = 3'h3;
  localparam logic [2:0] DM_NMI = 3'h4;
  localparam logic [2:0] DM_INIT = 3'h5;
  localparam logic [2:0] DM_RSVD_B = 3'h6;
  localparam logic [2:0] DM_EXTINT = 3'h7;
  // Remote read tail on the serial bus
  localparam logic [4:0] RR_DATA_LAST = 5'd15;
  localparam logic [4:0] RR_STATUS_CYC = 5'd16;
  localparam logic [4:0] RR_SUM_CYC = 5'd17;
  localparam logic [4:0] RR_IDLE_CYC = 5'd18;
  localparam logic [1:0] RR_STAT_VALID = 2'h0;
  localparam logic [1:0] RR_STAT_INVALID = 2'h3;
  localparam logic [1:0] BUS_IDLE = 2'h3;
  // Delivery sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WRITE} aid_state_t;
endpackage
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aid_pkg::*;
  localparam int N = IRQ_COUNT;
  logic clk_sys, rst, unitEn, extEn, parSel, capFlag, tgtWrite, tgtClaim, upReq, upGrant, msgWrite;
  logic eoiValid, rrStart, rrDataValid, rrDrive;
  logic [N-1:0] irqPin, destLog, levTrig, pend;
  logic [N*8-1:0] destId, vec;
  logic [N*3-1:0] mode;
  logic [7:0] eoiVector;
  logic [31:0] tgtAddr, tgtData, msgAddr, msgData, rrData, d;
  logic [1:0] rrBits, grantDelay;
  logic [2:0] legal [3] = '{DM_FIXED, DM_LOWEST, DM_EXTINT};
  integer seed = 32'h77433b01;
  int num_errors = 0;
  int total_checks = 0;

  aid_msg_irq_ctrl dut (.clk_sys(clk_sys), .rst(rst), .interruptUnitEnable(unitEn),
    .extendedModeEnable(extEn), .parallelDeliverySelect(parSel), .pinAssertCapableFlag(capFlag),
    .irqPin(irqPin), .rteDestId(destId), .rteVector(vec), .rteDelivMode(mode),
    .rteDestLogical(destLog), .rteLevelTrig(levTrig), .eoiValid(eoiValid), .eoiVector(eoiVector),
    .tgtWrite(tgtWrite), .tgtAddr(tgtAddr), .tgtData(tgtData), .tgtClaim(tgtClaim), .upReq(upReq),
    .upGrant(upGrant), .msgWrite(msgWrite), .msgAddr(msgAddr), .msgData(msgData),
    .requestPendingBit(pend), .rrStart(rrStart), .rrData(rrData), .rrDataValid(rrDataValid),
    .rrDrive(rrDrive), .rrBits(rrBits));

  aid_host_model host (.clk_sys(clk_sys), .rst(rst), .upReq(upReq), .grantDelay(grantDelay),
    .upGrant(upGrant));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function logic [31:0] eAddr(int n);
    return {MSG_ADDR_TOP, destId[n*8+:8], MSG_ADDR_RSVD, mode[n*3+:3] == DM_LOWEST, destLog[n], MSG_ADDR_LOW};
  endfunction

  function logic [31:0] eData(int n, logic st);
    return {MSG_DATA_TOP, levTrig[n], levTrig[n] ? st : 1'b1, MSG_DATA_RSVD, destLog[n], mode[n*3+:3],
      vec[n*8+:8]};
  endfunction

  task pci_wr(input logic [31:0] a, input logic [31:0] dat, input logic claim);
    @(posedge clk_sys);
    tgtWrite <= 1'b1;
    tgtAddr <= a;
    tgtData <= dat;
    @(posedge clk_sys);
    tgtWrite <= 1'b0;
    #1;
    chk(32'(tgtClaim), 32'(claim));
  endtask

  // Counts message writes in a fixed window, with random grant delays
  task wait_msg(input int exp, input int n, input logic st);
    int cnt;
    cnt = 0;
    for (int c = 0; c < 40; c++) begin
      @(posedge clk_sys);
      // One grant delay per window, so the host model always meets it
      if (c == 0) grantDelay <= 2'($random(seed));
      #1;
      if (msgWrite === 1'b1) begin
        cnt++;
        chk(msgAddr, eAddr(n));
        chk(msgData, eData(n, st));
      end
    end
    chk(32'(cnt), 32'(exp));
  endtask

  task rr(input logic [31:0] dat, input logic v);
    logic [1:0] sum;
    sum = 2'h0;
    for (int i = 0; i < 16; i++) sum += dat[2*i+:2];
    @(posedge clk_sys);
    rrStart <= 1'b1;
    rrData <= dat;
    rrDataValid <= v;
    @(posedge clk_sys);
    rrStart <= 1'b0;
    for (int c = 1; c <= 19; c++) begin
      #1;
      chk(32'(rrBits), 32'(c <= 16 ? dat[33-2*c-:2] : c == 17 ? (v ? RR_STAT_VALID : RR_STAT_INVALID) : c == 18 ? sum : BUS_IDLE));
      @(posedge clk_sys);
      rrStart <= (c == 4);
    end
    #1;
    chk(32'(rrDrive), 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    unitEn = 1'b1;
    extEn = 1'b0;
    parSel = 1'b1;
    irqPin = '0;
    levTrig = '0;
    tgtWrite = 1'b0;
    tgtAddr = '0;
    tgtData = '0;
    eoiValid = 1'b0;
    eoiVector = '0;
    rrStart = 1'b0;
    rrData = '0;
    rrDataValid = 1'b0;
    grantDelay = 2'h0;
    for (int i = 0; i < N; i++) begin
      destId[i*8+:8] = 8'($random(seed));
      vec[i*8+:8] = 8'($random(seed));
      destLog[i] = 1'($random(seed));
      mode[i*3+:3] = legal[$unsigned($random(seed)) % 3];
    end
    // Entries 3 to 7 carry modes that must never go out
    mode[9+:3] = DM_SMI;
    mode[12+:3] = DM_NMI;
    mode[15+:3] = DM_INIT;
    mode[18+:3] = DM_RSVD_A;
    mode[21+:3] = DM_RSVD_B;
    mode[3+:3] = DM_LOWEST;
    mode[27+:3] = DM_EXTINT;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(32'(capFlag), 32'h0);
    pci_wr(PIN_ASSERT_ADDR, 32'h5, 1'b0);
    @(posedge clk_sys);
    extEn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'(capFlag), 32'h1);
    @(posedge clk_sys);
    unitEn <= 1'b0;
    pci_wr(PIN_ASSERT_ADDR, 32'h5, 1'b0);
    @(posedge clk_sys);
    unitEn <= 1'b1;
    pci_wr(PIN_ASSERT_ADDR + 32'h4, 32'h5, 1'b0);
    @(posedge clk_sys);
    parSel <= 1'b0;
    pci_wr(PIN_ASSERT_ADDR, 32'hc, 1'b1);
    wait_msg(0, 12, 1'b1);
    chk(32'(pend[12]), 32'h1);
    @(posedge clk_sys);
    parSel <= 1'b1;
    wait_msg(1, 12, 1'b1);
    for (int n = 0; n < 32; n++) begin
      d = $random(seed);
      d[4:0] = 5'(n);
      pci_wr(PIN_ASSERT_ADDR, d, 1'b1);
      wait_msg(int'(n < N && !(n inside {0, 2, 8, 13}) && !(n inside {[3:7]})), n, 1'b1);
      chk(32'(pend), 32'h0);
    end
    @(posedge clk_sys);
    irqPin[9] <= 1'b1;
    wait_msg(1, 9, 1'b1);
    wait_msg(0, 9, 1'b1);
    @(posedge clk_sys);
    irqPin[9] <= 1'b0;
    wait_msg(0, 9, 1'b0);
    @(posedge clk_sys);
    levTrig[10] <= 1'b1;
    irqPin[10] <= 1'b1;
    wait_msg(1, 10, 1'b1);
    wait_msg(0, 10, 1'b1);
    @(posedge clk_sys);
    eoiValid <= 1'b1;
    eoiVector <= vec[80+:8];
    @(posedge clk_sys);
    eoiValid <= 1'b0;
    wait_msg(1, 10, 1'b1);
    @(posedge clk_sys);
    irqPin[10] <= 1'b0;
    wait_msg(0, 10, 1'b0);
    chk(32'(pend[10]), 32'h0);
    // Level change sets, then clears, a held request
    @(posedge clk_sys);
    parSel <= 1'b0;
    irqPin[10] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(32'(pend[10]), 32'h1);
    @(posedge clk_sys);
    irqPin[10] <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(32'(pend[10]), 32'h0);
    for (int k = 0; k < 4; k++) rr($random(seed), k[0]);
    finish_test();
  end
endmodule
`default_nettype wire
